// >>> common/ext_irq_pkg.sv
`default_nettype none

package ext_irq_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] STATUS_CTRL_OFF = 4'h0;
    localparam logic [ADDR_W-1:0] BREAK_CTRL_OFF  = 4'h1;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_BIT = 0;
    localparam int MASK_BIT = 1;
    localparam int ACK_BIT  = 2;
    localparam int PEND_BIT = 3;
    localparam int CLR_EN_BIT = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic              MODE_RST  = 1'b0;
    localparam logic              MASK_RST  = 1'b0;
    localparam logic              CLR_EN_RST = 1'b0;
    localparam logic              PIN_RST   = 1'b1;
    localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;

    // ------------------------------------------------------------
    // vector location
    // ------------------------------------------------------------
    localparam logic [15:0] VECTOR_HI_ADDR = 16'hFFFA;
    localparam logic [15:0] VECTOR_LO_ADDR = 16'hFFFB;

    // ------------------------------------------------------------
    // request state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        REQ_IDLE,
        REQ_PENDING,
        REQ_ACKED
    } req_state_t;

endpackage : ext_irq_pkg

`default_nettype wire

// >>> src/external_irq_pin_latch.sv
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module external_irq_pin_latch
(
    input  wire logic                           sys_clk_i,
    input  wire logic                           reset_i,
    input  wire logic                           irq_pin_n_i,
    input  wire logic                           vector_fetch_i,
    input  wire logic                           break_state_i,
    input  wire logic [ext_irq_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [ext_irq_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                           write_i,
    input  wire logic                           read_i,
    output logic      [ext_irq_pkg::DATA_W-1:0] rdata_o,
    output logic                                irq_request_o,
    output logic      [15:0]                    vector_addr_o,
    output logic                                pin_level_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic                           sync1_r;
    logic                           sync2_r;
    logic                           prev_r;
    logic [2:0]                     fill_r;
    logic                           falling;
    logic                           pin_low;
    logic                           mode_r;
    logic                           mask_r;
    logic                           break_clear_enable_r;
    logic                           sw_ack;
    logic                           ack;
    logic                           latched;
    ext_irq_pkg::req_state_t        state_r;
    ext_irq_pkg::req_state_t        state_nxt;
    logic [ext_irq_pkg::DATA_W-1:0] rdata_r;
    logic [ext_irq_pkg::DATA_W-1:0] rdata_nxt;
    logic                           irq_req_r;
    logic [15:0]                    vector_r;

    function automatic logic hit
    (
        input logic [ext_irq_pkg::ADDR_W-1:0] a,
        input logic [ext_irq_pkg::ADDR_W-1:0] off
    );
        hit = (a == off);
    endfunction : hit

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    // stage one feeds only stage two; edges wait until the chain is filled
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sync1_r <= ext_irq_pkg::PIN_RST;
            sync2_r <= ext_irq_pkg::PIN_RST;
            prev_r  <= ext_irq_pkg::PIN_RST;
            fill_r  <= 3'h0;
        end
        else
        begin
            sync1_r <= irq_pin_n_i;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
            fill_r  <= {fill_r[1:0], 1'b1};
        end
    end

    assign falling = fill_r[2] & prev_r & ~sync2_r;
    assign pin_low = ~sync2_r;

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            mode_r <= ext_irq_pkg::MODE_RST;
            mask_r <= ext_irq_pkg::MASK_RST;
        end
        else if (write_i && hit(addr_i, ext_irq_pkg::STATUS_CTRL_OFF))
        begin
            mode_r <= wdata_i[ext_irq_pkg::MODE_BIT];
            mask_r <= wdata_i[ext_irq_pkg::MASK_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            break_clear_enable_r <= ext_irq_pkg::CLR_EN_RST;
        end
        else if (write_i && hit(addr_i, ext_irq_pkg::BREAK_CTRL_OFF))
        begin
            break_clear_enable_r <= wdata_i[ext_irq_pkg::CLR_EN_BIT];
        end
    end

    // ------------------------------------------------------------
    // acknowledge
    // ------------------------------------------------------------
    // in break a software write only counts when break clear is enabled
    assign sw_ack = write_i && hit(addr_i, ext_irq_pkg::STATUS_CTRL_OFF)
                  && wdata_i[ext_irq_pkg::ACK_BIT]
                  && (!break_state_i || break_clear_enable_r);
    assign ack    = vector_fetch_i | sw_ack;

    // ------------------------------------------------------------
    // request latch
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        if (falling)
        begin
            state_nxt = ext_irq_pkg::REQ_PENDING;
        end
        else
        begin
            case (state_r)
                ext_irq_pkg::REQ_IDLE:
                begin
                    if (mode_r && pin_low)
                    begin
                        state_nxt = ext_irq_pkg::REQ_PENDING;
                    end
                end
                ext_irq_pkg::REQ_PENDING:
                begin
                    if (ack && !mode_r)
                    begin
                        state_nxt = ext_irq_pkg::REQ_IDLE;
                    end
                    else if (ack && pin_low)
                    begin
                        state_nxt = ext_irq_pkg::REQ_ACKED;
                    end
                    else if (ack)
                    begin
                        state_nxt = ext_irq_pkg::REQ_IDLE;
                    end
                end
                ext_irq_pkg::REQ_ACKED:
                begin
                    // mode dropped or pin back high after the ack: nothing left to wait for
                    if (!mode_r || !pin_low)
                    begin
                        state_nxt = ext_irq_pkg::REQ_IDLE;
                    end
                end
                default:
                begin
                    state_nxt = ext_irq_pkg::REQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_r <= ext_irq_pkg::REQ_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign latched = (state_r != ext_irq_pkg::REQ_IDLE);

    // ------------------------------------------------------------
    // cpu side
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            irq_req_r <= 1'b0;
            vector_r  <= ext_irq_pkg::VECTOR_HI_ADDR;
        end
        else
        begin
            irq_req_r <= latched & ~mask_r;
            vector_r  <= ext_irq_pkg::VECTOR_HI_ADDR;
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = ext_irq_pkg::RDATA_RST;
        if (read_i && hit(addr_i, ext_irq_pkg::STATUS_CTRL_OFF))
        begin
            rdata_nxt[ext_irq_pkg::MODE_BIT] = mode_r;
            rdata_nxt[ext_irq_pkg::MASK_BIT] = mask_r;
            rdata_nxt[ext_irq_pkg::PEND_BIT] = latched;
        end
        else if (read_i && hit(addr_i, ext_irq_pkg::BREAK_CTRL_OFF))
        begin
            rdata_nxt[ext_irq_pkg::CLR_EN_BIT] = break_clear_enable_r;
        end
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rdata_r <= ext_irq_pkg::RDATA_RST;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o       = rdata_r;
    assign irq_request_o = irq_req_r;
    assign vector_addr_o = vector_r;
    assign pin_level_o   = prev_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_ack_write;
        write_i && hit(addr_i, ext_irq_pkg::STATUS_CTRL_OFF)
        && wdata_i[ext_irq_pkg::ACK_BIT];
    endsequence

    sequence s_no_edge_quiet;
        !falling && !mode_r;
    endsequence

    property p_fall_sets;
        @(posedge sys_clk_i) disable iff (reset_i)
        fill_r[2] && prev_r && !sync2_r |=> latched;
    endproperty
    a_fall_sets: assert property (p_fall_sets)
        else $error("falling edge did not set the latch");

    property p_edge_ack_clears;
        @(posedge sys_clk_i) disable iff (reset_i)
        vector_fetch_i and s_no_edge_quiet |=> !latched;
    endproperty
    a_edge_ack_clears: assert property (p_edge_ack_clears)
        else $error("edge mode acknowledge did not clear");

    property p_vec_ack;
        @(posedge sys_clk_i) disable iff (reset_i)
        vector_fetch_i && mode_r && !falling && !pin_low
        && state_r == ext_irq_pkg::REQ_PENDING |=> !latched;
    endproperty
    a_vec_ack: assert property (p_vec_ack)
        else $error("vector fetch did not clear a level request");

    property p_sw_ack;
        @(posedge sys_clk_i) disable iff (reset_i)
        s_ack_write and !break_state_i and s_no_edge_quiet
        |=> !latched;
    endproperty
    a_sw_ack: assert property (p_sw_ack)
        else $error("software acknowledge did not clear");

    property p_level_hold;
        @(posedge sys_clk_i) disable iff (reset_i)
        mode_r && latched && !sync1_r && !sync2_r
        |=> latched [*2];
    endproperty
    a_level_hold: assert property (p_level_hold)
        else $error("level request dropped while pin low");

    property p_level_clear;
        @(posedge sys_clk_i) disable iff (reset_i)
        state_r == ext_irq_pkg::REQ_ACKED && !pin_low && !falling
        |=> !latched;
    endproperty
    a_level_clear: assert property (p_level_clear)
        else $error("acked level request not cleared on pin high");

    property p_refire;
        @(posedge sys_clk_i) disable iff (reset_i)
        s_ack_write ##1 falling |=> latched;
    endproperty
    a_refire: assert property (p_refire)
        else $error("edge after acknowledge was lost");

    property p_break_block;
        @(posedge sys_clk_i) disable iff (reset_i)
        s_ack_write and (break_state_i && !break_clear_enable_r
        && !vector_fetch_i && state_r == ext_irq_pkg::REQ_PENDING)
        |=> state_r == ext_irq_pkg::REQ_PENDING;
    endproperty
    a_break_block: assert property (p_break_block)
        else $error("acknowledge in break changed the latch");

    property p_break_clear;
        @(posedge sys_clk_i) disable iff (reset_i)
        s_ack_write and break_state_i and break_clear_enable_r
        and s_no_edge_quiet |=> !latched;
    endproperty
    a_break_clear: assert property (p_break_clear)
        else $error("acknowledge in break with clear enabled failed");

    property p_irq_out;
        @(posedge sys_clk_i) disable iff (reset_i)
        (latched && !mask_r) [*2] |-> irq_request_o;
    endproperty
    a_irq_out: assert property (p_irq_out)
        else $error("unmasked request not presented");

    property p_mask_out;
        @(posedge sys_clk_i) disable iff (reset_i)
        mask_r [*2] |-> !irq_request_o;
    endproperty
    a_mask_out: assert property (p_mask_out)
        else $error("masked request presented");

    property p_pending_flag;
        @(posedge sys_clk_i) disable iff (reset_i)
        read_i && hit(addr_i, ext_irq_pkg::STATUS_CTRL_OFF)
        |=> rdata_o[ext_irq_pkg::PEND_BIT] == $past(latched);
    endproperty
    a_pending_flag: assert property (p_pending_flag)
        else $error("pending flag wrong");

    property p_pin_level;
        @(posedge sys_clk_i) disable iff (reset_i)
        $past(!reset_i) && $past(!reset_i, 2) && $past(!reset_i, 3)
        |-> pin_level_o == $past(irq_pin_n_i, 3);
    endproperty
    a_pin_level: assert property (p_pin_level)
        else $error("pin level not three cycles behind the pin");

    property p_reset_clear;
        @(posedge sys_clk_i) disable iff (reset_i)
        $past(reset_i) |-> !latched && !mode_r;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset left latch or mode set");
endmodule : external_irq_pin_latch
`default_nettype wire

// >>> test/external_irq_pin_latch_test.sv
`timescale 1ns/100ps
`default_nettype none

module external_irq_pin_latch_test;
    localparam logic [3:0] SC = ext_irq_pkg::STATUS_CTRL_OFF;
    localparam logic [3:0] BC = ext_irq_pkg::BREAK_CTRL_OFF;
    logic        sys_clk_i, reset_i, vf, brk, wr_s, rd_s, rd_d;
    logic [3:0]  addr;
    logic [7:0]  wdat, rdat, lfsr;
    logic [15:0] vec;
    logic        req, lvl, pin_n, low, slow;
    int          num_errors, total_checks;
    logic [7:0]  exp_q[$];

    always #4 sys_clk_i = ~sys_clk_i;

    irq_source_model u_src (.sys_clk_i(sys_clk_i), .drive_low_i(low),
        .slow_i(slow), .pin_n_o(pin_n));

    external_irq_pin_latch u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .irq_pin_n_i(pin_n), .vector_fetch_i(vf), .break_state_i(brk),
        .addr_i(addr), .wdata_i(wdat), .write_i(wr_s), .read_i(rd_s),
        .rdata_o(rdat), .irq_request_o(req), .vector_addr_o(vec),
        .pin_level_o(lvl));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nxt

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("mismatch %s expected %0h seen %0h", n, e, g);
            num_errors++;
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdat <= d;
        wr_s <= 1'b1;
        @(posedge sys_clk_i);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        addr <= a;
        rd_s <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk_i);
        rd_s <= 1'b0;
    endtask : rd

    // random pace, so the pin source is sometimes slow
    task automatic pin(input logic v);
        @(posedge sys_clk_i);
        low  <= v;
        slow <= lfsr[0];
        lfsr = nxt(lfsr);
        if (!v)
            repeat (10) @(posedge sys_clk_i);
    endtask : pin

    task automatic fetch;
        @(posedge sys_clk_i);
        vf <= 1'b1;
        @(posedge sys_clk_i);
        vf <= 1'b0;
    endtask : fetch

    // bounded wait; a hang ends the run
    task automatic wait_req(input logic e);
        int n;
        n = 0;
        while (req !== e && n < 20)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        chk("irq_request", {15'h0, e}, {15'h0, req});
        if (req !== e)
            tally_and_finish();
    endtask : wait_req

    // ----------------------------------------
    // read data monitor
    // ----------------------------------------
    always @(posedge sys_clk_i)
        rd_d <= rd_s;

    always @(negedge sys_clk_i)
    begin
        if (rd_d)
            chk("rdata", {8'h0, exp_q.pop_front()}, {8'h0, rdat});
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        num_errors++;
        tally_and_finish();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        sys_clk_i = 1'b0;
        reset_i = 1'b1;
        {vf, brk, wr_s, rd_s, low, slow} = 6'h00;
        addr = 4'h0;
        wdat = 8'h00;
        lfsr = 8'h5C;
        num_errors = 0;
        total_checks = 0;
        repeat (20) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(negedge sys_clk_i);
        chk("vector_addr", 16'hFFFA, vec);
        chk("pin_level", 16'h0001, {15'h0, lvl});
        rd(SC, 8'h00);
        rd(BC, 8'h00);
        wr(4'h5, lfsr);
        rd(4'h5, 8'h00);
        wr(BC, {1'b0, lfsr[6:0]});
        rd(BC, 8'h00);
        // edge mode, vector fetch with pin still low
        pin(1'b1);
        wait_req(1'b1);
        chk("pin_level", 16'h0000, {15'h0, lvl});
        rd(SC, 8'h08);
        fetch();
        wait_req(1'b0);
        pin(1'b0);
        // masked request still visible, software ack
        wr(SC, 8'h02);
        pin(1'b1);
        repeat (10) @(posedge sys_clk_i);
        chk("irq_request", 16'h0000, {15'h0, req});
        rd(SC, 8'h0A);
        wr(SC, 8'h06);
        rd(SC, 8'h02);
        pin(1'b0);
        pin(1'b1);
        repeat (10) @(posedge sys_clk_i);
        rd(SC, 8'h0A);
        wr(SC, 8'h04);
        rd(SC, 8'h00);
        pin(1'b0);
        // level mode: ack first, then pin high
        wr(SC, 8'h01);
        pin(1'b1);
        wait_req(1'b1);
        wr(SC, 8'h07);
        repeat (6) @(posedge sys_clk_i);
        rd(SC, 8'h0B);
        wr(SC, 8'h01);
        repeat (3) @(posedge sys_clk_i);
        chk("irq_request", 16'h0001, {15'h0, req});
        low <= 1'b0;
        wait_req(1'b0);
        // level mode: pin high first, then vector fetch
        repeat (8) @(posedge sys_clk_i);
        pin(1'b1);
        wait_req(1'b1);
        pin(1'b0);
        chk("irq_request", 16'h0001, {15'h0, req});
        fetch();
        wait_req(1'b0);
        // break state
        wr(SC, 8'h00);
        brk <= 1'b1;
        pin(1'b1);
        wait_req(1'b1);
        wr(SC, 8'h04);
        repeat (4) @(posedge sys_clk_i);
        rd(SC, 8'h08);
        wr(BC, 8'h80);
        rd(BC, 8'h80);
        wr(SC, 8'h04);
        wait_req(1'b0);
        @(posedge sys_clk_i);
        brk <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        rd(SC, 8'h00);
        pin(1'b0);
        // reset in mid-run, level mode, pin low
        wr(SC, 8'h01);
        pin(1'b1);
        wait_req(1'b1);
        @(posedge sys_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        chk("irq_request", 16'h0000, {15'h0, req});
        reset_i <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        chk("irq_request", 16'h0000, {15'h0, req});
        rd(SC, 8'h00);
        rd(BC, 8'h00);
        pin(1'b0);
        // back-to-back random rounds, edge mode
        repeat (4)
        begin
            pin(1'b1);
            wait_req(1'b1);
            fetch();
            wait_req(1'b0);
            pin(1'b0);
            repeat (lfsr[2:0]) @(posedge sys_clk_i);
        end
        repeat (4) @(posedge sys_clk_i);
        tally_and_finish();
    end
endmodule : external_irq_pin_latch_test

`default_nettype wire

// >>> test/irq_source_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// external request source
// ----------------------------------------
module irq_source_model
(
    input  wire logic sys_clk_i,
    input  wire logic drive_low_i,
    input  wire logic slow_i,
    output logic      pin_n_o
);
    // pull-up: pin rests high until the source pulls it
    logic       pin_r = 1'b1;
    logic [1:0] lag_r = 2'h0;

    assign pin_n_o = pin_r;

    // slow source lags a few cycles behind the command
    always @(posedge sys_clk_i)
    begin
        if (pin_n_o == drive_low_i)
        begin
            if (!slow_i || lag_r == 2'h3)
            begin
                pin_r   <= ~drive_low_i;
                lag_r   <= 2'h0;
            end
            else
                lag_r <= lag_r + 2'h1;
        end
        else
            lag_r <= 2'h0;
    end
endmodule : irq_source_model

`default_nettype wire
